// >>> design/mbc_brake_cfg.sv
// brake and command configuration registers with brake sequencer and speed/command thresholds
`timescale 1ns/1ps
module mbc_brake_cfg #(
  parameter logic [6:0] I2C_DEV_ADDR = 7'h55, // arbitrary default
  parameter logic [15:0] PULSE_BASE_CYC = 16'(mbc_pkg::STOP_PULSE_BASE_CYC)
) (
  input wire logic CORE_CLK_IN, // 10 MHz system clock
  input wire logic RESET_IN, // synchronous, active high
  input wire logic SCL_IN, // serial clock pin
  input wire logic SDA_IN, // serial data pin level
  output logic SDA_OUT, // data drive value, always low
  output logic SDA_OE_OUT, // data pin driven low
  input wire logic [15:0] SPEED_IN, // rotor speed, fraction of maximum
  input wire logic [15:0] COMMAND_IN, // external command, fraction of maximum
  input wire mbc_pkg::mbc_cond_t CONDITION_IN, // motor conditions from control logic
  input wire logic TIMER_TICK_IN, // system timer interrupt pulse
  output logic LS_FET_BRAKE_OUT, // all low-side FETs on
  output logic CONST_CURR_BRAKE_OUT, // constant-current braking
  output logic COASTING_OUT, // coasting before brake
  output logic BRAKE_ACTIVE_OUT, // any brake sequence running
  output logic FOC_DECEL_OUT, // reverse handled by field-control decel
  output logic OVERSPEED_OUT, // too fast to brake
  output logic STATIONARY_OUT, // rotor considered stopped
  output logic OBSERVER_VALID_OUT, // observer output trustworthy
  output logic MOTOR_ON_OUT, // command hysteresis result
  output logic [15:0] DEFAULT_CMD_OUT, // default command level
  output logic [15:0] BACKEMF_AMP_OUT, // compensation amplitude, fraction of nominal
  output logic BACKEMF_EN_OUT // compensator enabled
);
  mbc_pkg::mbc_brake_cfg_t brk_q;
  mbc_pkg::mbc_thr_cfg_t thr_q;
  logic [31:0] brk_nvm_q, thr_nvm_q;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic reg_wr;

  // product n+add1 scaled by a power of two, used by every threshold
  function automatic logic [16:0] scale(input logic [6:0] n, input logic add1, input logic [3:0] sh);
    logic [16:0] v;
    v = {10'h000, n} + {16'h0000, add1};
    return v << sh;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  mbc_i2c_slave #(
    .DEV_ADDR(I2C_DEV_ADDR)
  ) u_i2c (
    .clk_in(CORE_CLK_IN),
    .reset_in(RESET_IN),
    .scl_in(SCL_IN),
    .sda_in(SDA_IN),
    .sda_oe_out(SDA_OE_OUT),
    .reg_addr_out(reg_addr),
    .reg_wdata_out(reg_wdata),
    .reg_wr_out(reg_wr),
    .reg_rdata_in(reg_rdata)
  );

  assign SDA_OUT = 1'b0;

  // the shadow words steer the logic; the non-volatile words are plain storage
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      brk_q <= mbc_pkg::BRAKE_CFG_RESET;
      thr_q <= mbc_pkg::SPEED_CMD_RESET;
      brk_nvm_q <= mbc_pkg::BRAKE_CFG_RESET;
      thr_nvm_q <= mbc_pkg::SPEED_CMD_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        mbc_pkg::BRAKE_CFG_SHADOW_ADDR: brk_q <= reg_wdata & mbc_pkg::BRAKE_CFG_WMASK;
        mbc_pkg::SPEED_CMD_SHADOW_ADDR: thr_q <= reg_wdata & mbc_pkg::SPEED_CMD_WMASK;
        mbc_pkg::BRAKE_CFG_NVM_ADDR: brk_nvm_q <= reg_wdata & mbc_pkg::BRAKE_CFG_WMASK;
        mbc_pkg::SPEED_CMD_NVM_ADDR: thr_nvm_q <= reg_wdata & mbc_pkg::SPEED_CMD_WMASK;
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    case (reg_addr)
      mbc_pkg::BRAKE_CFG_SHADOW_ADDR: reg_rdata = brk_q;
      mbc_pkg::SPEED_CMD_SHADOW_ADDR: reg_rdata = thr_q;
      mbc_pkg::BRAKE_CFG_NVM_ADDR: reg_rdata = brk_nvm_q;
      mbc_pkg::SPEED_CMD_NVM_ADDR: reg_rdata = thr_nvm_q;
      default: reg_rdata = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // thresholds
  logic [16:0] over_lim, stat_lim, obs_lim, on_lvl, off_lvl, dflt, amp;
  assign over_lim = scale({2'h0, brk_q.overspeed_stop_limit}, 1'b1, mbc_pkg::OVERSPEED_SHIFT);
  assign stat_lim = scale(thr_q.stationary_speed_limit, 1'b1, mbc_pkg::STATIONARY_SHIFT);
  assign obs_lim = scale({4'h0, thr_q.observer_valid_speed}, 1'b1, mbc_pkg::OBSERVER_SHIFT);
  assign on_lvl = scale({1'b0, thr_q.command_turn_on_level}, 1'b1, mbc_pkg::CMD_LEVEL_SHIFT);
  assign off_lvl = scale({1'b0, thr_q.command_turn_off_level}, 1'b0, mbc_pkg::CMD_LEVEL_SHIFT);
  assign dflt = scale({1'b0, thr_q.default_command_level}, 1'b0, mbc_pkg::DEFAULT_CMD_SHIFT);
  assign amp = scale({1'b0, brk_q.backemf_comp_amp}, 1'b0, mbc_pkg::BACKEMF_SHIFT);

  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      OVERSPEED_OUT <= 1'b0;
      STATIONARY_OUT <= 1'b1;
      OBSERVER_VALID_OUT <= 1'b0;
      DEFAULT_CMD_OUT <= 16'h0000;
      BACKEMF_AMP_OUT <= 16'h0000;
      BACKEMF_EN_OUT <= 1'b0;
      FOC_DECEL_OUT <= 1'b0;
    end else begin
      OVERSPEED_OUT <= {1'b0, SPEED_IN} > over_lim;
      STATIONARY_OUT <= {1'b0, SPEED_IN} < stat_lim;
      OBSERVER_VALID_OUT <= {1'b0, SPEED_IN} >= obs_lim;
      DEFAULT_CMD_OUT <= dflt[15:0];
      BACKEMF_AMP_OUT <= amp[15:0];
      BACKEMF_EN_OUT <= brk_q.backemf_comp_amp != 6'h00;
      FOC_DECEL_OUT <= CONDITION_IN.reverse & ~brk_q.reverse_stop_mode;
    end
  end

  // on wins over off when levels are misprogrammed to overlap
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      MOTOR_ON_OUT <= 1'b0;
    end else if ({1'b0, COMMAND_IN} >= on_lvl) begin
      MOTOR_ON_OUT <= 1'b1;
    end else if ({1'b0, COMMAND_IN} <= off_lvl) begin
      MOTOR_ON_OUT <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // brake sequencer
  mbc_pkg::mbc_brk_st_t st_q;
  logic [15:0] cyc_q, on_cyc;
  logic [17:0] off_cyc;
  logic [8:0] pcnt_q, pulse_last, coast_q, coast_ticks;
  logic [7:0] rep_q, seq_last;
  logic demand, pulse_end;

  assign demand = CONDITION_IN.ext_brake
    | (CONDITION_IN.reverse & brk_q.reverse_stop_mode)
    | (CONDITION_IN.windmill & brk_q.windmill_force_stop_en)
    | (CONDITION_IN.cmd_off & brk_q.off_stop_en)
    | (CONDITION_IN.soft_off & thr_q.soft_off_stop_en);

  assign on_cyc = PULSE_BASE_CYC << brk_q.stop_pulse_on_time;
  assign off_cyc = {2'h0, on_cyc} * {16'h0000, brk_q.stop_pulse_off_mult};
  assign pulse_last = 9'((10'h002 << brk_q.stop_pulse_count) - 10'h001);
  assign seq_last = 8'((9'h002 << brk_q.stop_sequence_len) - 9'h002);
  assign coast_ticks = 9'(10'h002 << brk_q.coast_time);
  // a pulse ends after its off gap, or after its on time when no gap is set
  assign pulse_end = (st_q == mbc_pkg::BS_OFF && {2'h0, cyc_q} == off_cyc - 18'h00001)
    || (st_q == mbc_pkg::BS_ON && cyc_q == on_cyc - 16'h0001 && brk_q.stop_pulse_off_mult == 2'h0);

  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      st_q <= mbc_pkg::BS_IDLE;
      cyc_q <= 16'h0000;
      pcnt_q <= 9'h000;
      rep_q <= 8'h00;
      coast_q <= 9'h000;
    end else if (!demand) begin
      st_q <= mbc_pkg::BS_IDLE;
    end else begin
      case (st_q)
        mbc_pkg::BS_IDLE: begin
          cyc_q <= 16'h0000;
          pcnt_q <= 9'h000;
          rep_q <= 8'h00;
          coast_q <= 9'h000;
          if (OVERSPEED_OUT) begin
            st_q <= mbc_pkg::BS_COAST;
          end else begin
            st_q <= brk_q.stop_method ? mbc_pkg::BS_CCUR : mbc_pkg::BS_ON;
          end
        end
        mbc_pkg::BS_COAST: begin
          if (TIMER_TICK_IN) begin
            coast_q <= coast_q + 9'h001;
            if (coast_q == coast_ticks - 9'h001) begin
              st_q <= brk_q.stop_method ? mbc_pkg::BS_CCUR : mbc_pkg::BS_ON;
            end
          end
        end
        mbc_pkg::BS_ON, mbc_pkg::BS_OFF: begin
          cyc_q <= cyc_q + 16'h0001;
          if (pulse_end) begin
            cyc_q <= 16'h0000;
            st_q <= mbc_pkg::BS_ON;
            if (pcnt_q != pulse_last) begin
              pcnt_q <= pcnt_q + 9'h001;
            end else if (rep_q != seq_last) begin
              pcnt_q <= 9'h000;
              rep_q <= rep_q + 8'h01;
            end else begin
              st_q <= mbc_pkg::BS_HOLD;
            end
          end else if (st_q == mbc_pkg::BS_ON && cyc_q == on_cyc - 16'h0001) begin
            cyc_q <= 16'h0000;
            st_q <= mbc_pkg::BS_OFF;
          end
        end
        mbc_pkg::BS_HOLD, mbc_pkg::BS_CCUR: begin
        end
        default: st_q <= mbc_pkg::BS_IDLE;
      endcase
    end
  end

  // after the last pulse train the low-side FETs stay on while braking is wanted
  assign LS_FET_BRAKE_OUT = (st_q == mbc_pkg::BS_ON) || (st_q == mbc_pkg::BS_HOLD);
  assign CONST_CURR_BRAKE_OUT = st_q == mbc_pkg::BS_CCUR;
  assign COASTING_OUT = st_q == mbc_pkg::BS_COAST;
  assign BRAKE_ACTIVE_OUT = st_q != mbc_pkg::BS_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  method_entry_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    (st_q != mbc_pkg::BS_CCUR) ##1 (st_q == mbc_pkg::BS_CCUR) |-> $past(brk_q.stop_method))
    else $error("constant current entered with method bit clear");
  reverse_decel_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    CONDITION_IN.reverse && !brk_q.reverse_stop_mode |=> FOC_DECEL_OUT)
    else $error("reverse did not select decel");
  brake_start_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    (st_q == mbc_pkg::BS_IDLE) && CONDITION_IN.cmd_off && brk_q.off_stop_en |=> BRAKE_ACTIVE_OUT)
    else $error("off brake did not start");
  windmill_brake_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    (CONDITION_IN.windmill && brk_q.windmill_force_stop_en) [*2] |-> BRAKE_ACTIVE_OUT)
    else $error("windmill brake not running");
  seq_length_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    (st_q != mbc_pkg::BS_HOLD) ##1 (st_q == mbc_pkg::BS_HOLD) |-> $past(rep_q) == $past(seq_last)
      && $past(pcnt_q) == $past(pulse_last))
    else $error("hold reached with wrong train or pulse count");
  on_time_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    st_q == mbc_pkg::BS_ON |-> cyc_q < on_cyc)
    else $error("pulse on time overrun");
  off_time_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    st_q == mbc_pkg::BS_OFF |-> {2'h0, cyc_q} < off_cyc)
    else $error("pulse off time overrun or gap with zero multiplier");
  overspeed_coast_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    (st_q == mbc_pkg::BS_IDLE) && demand && OVERSPEED_OUT |=> COASTING_OUT || !demand)
    else $error("overspeed brake did not coast");
  coast_time_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    COASTING_OUT |-> coast_q < coast_ticks)
    else $error("coast ran past its tick count");
  stationary_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    ##1 (STATIONARY_OUT && !$past(RESET_IN)) |-> {1'b0, $past(SPEED_IN)} < $past(stat_lim))
    else $error("stationary flagged above limit");
  motor_on_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    $rose(MOTOR_ON_OUT) |-> {1'b0, $past(COMMAND_IN)} >= $past(on_lvl))
    else $error("motor turned on below on level");
  motor_off_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    $fell(MOTOR_ON_OUT) |-> {1'b0, $past(COMMAND_IN)} <= $past(off_lvl))
    else $error("motor turned off above off level");
  backemf_en_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    BACKEMF_EN_OUT == (BACKEMF_AMP_OUT != 16'h0000))
    else $error("compensator enable disagrees with amplitude");
  seq_restart_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    (st_q == mbc_pkg::BS_IDLE) ##1 (st_q != mbc_pkg::BS_IDLE) |-> cyc_q == 16'h0000
      && pcnt_q == 9'h000 && rep_q == 8'h00 && coast_q == 9'h000)
    else $error("counters not restarted at sequence start");
endmodule

// >>> pkg/mbc_pkg.sv
// constants, register map and carrier types for the brake and command configuration block
package mbc_pkg;
  localparam logic [15:0] BRAKE_CFG_SHADOW_ADDR = 16'h0471;
  localparam logic [15:0] SPEED_CMD_SHADOW_ADDR = 16'h0472;
  localparam logic [15:0] BRAKE_CFG_NVM_ADDR = 16'h04D1;
  localparam logic [15:0] SPEED_CMD_NVM_ADDR = 16'h04D2;
  localparam logic [31:0] BRAKE_CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] SPEED_CMD_RESET = 32'h0000_0000;
  // reserved bits are stored as zero so they read back as zero
  localparam logic [31:0] BRAKE_CFG_WMASK = 32'hFFFF_FFFD;
  localparam logic [31:0] SPEED_CMD_WMASK = 32'h8FFF_FFFF;

  localparam int CLK_PERIOD_NS = 100;
  localparam int STOP_PULSE_BASE_NS = 11240;
  localparam int STOP_PULSE_BASE_CYC = (STOP_PULSE_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // speed and command are 16-bit fractions of full scale (65536 = 100 %)
  localparam logic [3:0] OVERSPEED_SHIFT = 4'hB;
  localparam logic [3:0] STATIONARY_SHIFT = 4'h4;
  localparam logic [3:0] OBSERVER_SHIFT = 4'h7;
  localparam logic [3:0] DEFAULT_CMD_SHIFT = 4'hA;
  localparam logic [3:0] CMD_LEVEL_SHIFT = 4'h8;
  localparam logic [3:0] BACKEMF_SHIFT = 4'h8;

  typedef struct packed {
    logic [5:0] backemf_comp_amp;
    logic [1:0] align_current_gain;
    logic [2:0] coast_time;
    logic [4:0] overspeed_stop_limit;
    logic [1:0] stop_pulse_off_mult;
    logic [2:0] stop_pulse_on_time;
    logic [2:0] stop_pulse_count;
    logic [2:0] stop_sequence_len;
    logic off_stop_en;
    logic windmill_force_stop_en;
    logic reverse_stop_mode;
    logic rsvd1;
    logic stop_method;
  } mbc_brake_cfg_t;

  typedef struct packed {
    logic soft_off_stop_en;
    logic [2:0] rsvd;
    logic [5:0] command_turn_off_level;
    logic [5:0] command_turn_on_level;
    logic [5:0] default_command_level;
    logic [2:0] observer_valid_speed;
    logic [6:0] stationary_speed_limit;
  } mbc_thr_cfg_t;

  typedef struct packed {
    logic ext_brake;
    logic reverse;
    logic windmill;
    logic cmd_off;
    logic soft_off;
  } mbc_cond_t;

  typedef enum logic [2:0] {I2C_IDLE, I2C_ADDR, I2C_WR, I2C_RD} mbc_i2c_st_t;
  typedef enum logic [2:0] {BS_IDLE, BS_COAST, BS_ON, BS_OFF, BS_HOLD, BS_CCUR} mbc_brk_st_t;
endpackage

// >>> design/mbc_i2c_slave.sv
// two-wire serial slave giving word access to the configuration registers
`timescale 1ns/1ps
module mbc_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h55
) (
  input wire logic clk_in, // system clock
  input wire logic reset_in, // synchronous, active high
  input wire logic scl_in, // serial clock pin
  input wire logic sda_in, // serial data pin level
  output logic sda_oe_out, // pull data low
  output logic [15:0] reg_addr_out, // register pointer
  output logic [31:0] reg_wdata_out, // assembled write word
  output logic reg_wr_out, // write strobe, one cycle
  input wire logic [31:0] reg_rdata_in // word at the pointer
);
  logic [2:0] scl_s_q, sda_s_q;
  mbc_pkg::mbc_i2c_st_t st_q;
  logic [3:0] cnt_q;
  logic [2:0] bi_q;
  logic [7:0] sh_q;
  logic [31:0] rsh_q;
  logic ack_q;
  logic scl_h, scl_p, sda_h, sda_p, rise, fall, start, stop;

  // bit 0 of each chain is the first synchroniser stage and feeds only bit 1
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
    end else begin
      scl_s_q <= {scl_s_q[1:0], scl_in};
      sda_s_q <= {sda_s_q[1:0], sda_in};
    end
  end

  assign scl_h = scl_s_q[1];
  assign scl_p = scl_s_q[2];
  assign sda_h = sda_s_q[1];
  assign sda_p = sda_s_q[2];
  assign rise = scl_h & ~scl_p;
  assign fall = ~scl_h & scl_p;
  assign start = scl_h & scl_p & sda_p & ~sda_h;
  assign stop = scl_h & scl_p & ~sda_p & sda_h;

  ////////////////////////////////////////////////////////////////////////////
  // byte 0/1: pointer high/low, then words msb first; pointer does not advance
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_q <= mbc_pkg::I2C_IDLE;
      cnt_q <= 4'h0;
      bi_q <= 3'h0;
      sh_q <= 8'h00;
      rsh_q <= 32'h0000_0000;
      ack_q <= 1'b0;
      sda_oe_out <= 1'b0;
      reg_addr_out <= 16'h0000;
      reg_wdata_out <= 32'h0000_0000;
      reg_wr_out <= 1'b0;
    end else begin
      reg_wr_out <= 1'b0;
      if (start) begin
        st_q <= mbc_pkg::I2C_ADDR;
        cnt_q <= 4'h0;
        ack_q <= 1'b0;
        sda_oe_out <= 1'b0;
      end else if (stop) begin
        st_q <= mbc_pkg::I2C_IDLE;
        ack_q <= 1'b0;
        sda_oe_out <= 1'b0;
      end else if (rise && st_q != mbc_pkg::I2C_IDLE) begin
        if (!ack_q) begin
          sh_q <= {sh_q[6:0], sda_h};
          cnt_q <= cnt_q + 4'h1;
        end else if (st_q == mbc_pkg::I2C_RD && sda_h) begin
          st_q <= mbc_pkg::I2C_IDLE; // master nack ends the read
        end
      end else if (fall) begin
        if (ack_q) begin
          ack_q <= 1'b0;
          cnt_q <= 4'h0;
          sda_oe_out <= (st_q == mbc_pkg::I2C_RD) & ~rsh_q[31];
          if (st_q == mbc_pkg::I2C_RD) begin
            rsh_q <= {rsh_q[30:0], 1'b0};
          end
        end else if (cnt_q == 4'h8) begin
          ack_q <= 1'b1;
          sda_oe_out <= 1'b0;
          case (st_q)
            mbc_pkg::I2C_ADDR: begin
              if (sh_q[7:1] == DEV_ADDR) begin
                sda_oe_out <= 1'b1;
                st_q <= sh_q[0] ? mbc_pkg::I2C_RD : mbc_pkg::I2C_WR;
                rsh_q <= reg_rdata_in;
                bi_q <= 3'h0;
              end else begin
                st_q <= mbc_pkg::I2C_IDLE;
              end
            end
            mbc_pkg::I2C_WR: begin
              sda_oe_out <= 1'b1;
              bi_q <= (bi_q == 3'h5) ? 3'h2 : bi_q + 3'h1;
              if (bi_q == 3'h0) begin
                reg_addr_out[15:8] <= sh_q;
              end else if (bi_q == 3'h1) begin
                reg_addr_out[7:0] <= sh_q;
              end else begin
                reg_wdata_out <= {reg_wdata_out[23:0], sh_q};
                reg_wr_out <= (bi_q == 3'h5);
              end
            end
            default: begin
            end
          endcase
        end else if (st_q == mbc_pkg::I2C_RD) begin
          sda_oe_out <= ~rsh_q[31];
          rsh_q <= {rsh_q[30:0], 1'b0};
        end
      end
    end
  end
endmodule

// >>> sim/mbc_i2c_master.sv
// two-wire bus master model standing in for the host on the serial port
`timescale 1ns/1ps
module mbc_i2c_master (
  input wire logic clk_in, // bench clock
  input wire logic sda_in, // resolved data line, pulled up
  output logic scl_out, // serial clock, idle high
  output logic sda_pull_out // high pulls data low
);
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end
  // five cycles a phase stays clear of the four-cycle minimum after the synchronisers
  task automatic hp();
    repeat (5) @(posedge clk_in);
  endtask
  task automatic bit_x(input logic b, output logic r);
    sda_pull_out <= ~b;
    hp();
    scl_out <= 1'b1;
    hp();
    r = sda_in;
    scl_out <= 1'b0;
    hp();
  endtask
  task automatic byte_x(input logic [7:0] d, input logic mack, output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], a);
      r[i] = a;
    end
    bit_x(mack, a);
    ack = ~a;
  endtask
  task automatic start();
    @(posedge clk_in);
    sda_pull_out <= 1'b0;
    hp();
    scl_out <= 1'b1;
    hp();
    sda_pull_out <= 1'b1;
    hp();
    scl_out <= 1'b0;
    hp();
  endtask
  task automatic stop();
    sda_pull_out <= 1'b1;
    hp();
    scl_out <= 1'b1;
    hp();
    sda_pull_out <= 1'b0;
    hp();
  endtask
  task automatic wr_word(input logic [15:0] p, input logic [31:0] d, input logic [6:0] dev, output logic ok);
    logic [47:0] f;
    logic [7:0] r;
    logic a;
    f = {p, d};
    start();
    byte_x({dev, 1'b0}, 1'b1, r, ok);
    for (int i = 5; i >= 0; i--) byte_x(f[i*8 +: 8], 1'b1, r, a);
    stop();
  endtask
  task automatic rd_word(input logic [15:0] p, input logic [6:0] dev, output logic [31:0] d, output logic ok);
    logic [7:0] r;
    logic a;
    start();
    byte_x({dev, 1'b0}, 1'b1, r, ok);
    byte_x(p[15:8], 1'b1, r, a);
    byte_x(p[7:0], 1'b1, r, a);
    start();
    byte_x({dev, 1'b1}, 1'b1, r, a);
    for (int i = 3; i >= 0; i--) begin
      byte_x(8'hFF, i == 0, r, a);
      d = {d[23:0], r};
    end
    stop();
  endtask
endmodule

// >>> sim/motor_brake_and_command_config_tb.sv
// self-checking bench for the brake and command configuration block
`timescale 1ns/1ps
module motor_brake_and_command_config_tb;
  logic clk = 1'b0, rst = 1'b1, tick = 1'b0, pull, scl, sda_oe, sda;
  logic [15:0] speed = '0, cmd = '0, dcmd, bemf;
  mbc_pkg::mbc_cond_t cond = '0;
  logic ls, cc, coast, act, foc, ov, st, ob, mon, bemf_en;
  int n_fail = 0;
  int n_checks = 0;
  logic [31:0] n_up, n_hi;
  logic ls_p;
  // {speed, command, overspeed, stationary, observer, motor on}, applied in order for hysteresis
  localparam logic [35:0] ROWS [6] = '{36'h000000004, 36'h003F08005, 36'h004003E81,
    36'h010003002, 36'h100003012, 36'h100107FFA};
  localparam logic [15:0] ADDRS [5] = '{16'h0471, 16'h0472, 16'h04D1, 16'h04D2, 16'h0470};
  assign sda = ~(sda_oe | pull);
  mbc_i2c_master u_master (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_pull_out(pull));
  mbc_brake_cfg #(.PULSE_BASE_CYC(16'h0004)) u_dut (.CORE_CLK_IN(clk), .RESET_IN(rst), .SCL_IN(scl),
    .SDA_IN(sda), .SDA_OUT(), .SDA_OE_OUT(sda_oe), .SPEED_IN(speed), .COMMAND_IN(cmd),
    .CONDITION_IN(cond), .TIMER_TICK_IN(tick), .LS_FET_BRAKE_OUT(ls), .CONST_CURR_BRAKE_OUT(cc),
    .COASTING_OUT(coast), .BRAKE_ACTIVE_OUT(act), .FOC_DECEL_OUT(foc), .OVERSPEED_OUT(ov),
    .STATIONARY_OUT(st), .OBSERVER_VALID_OUT(ob), .MOTOR_ON_OUT(mon), .DEFAULT_CMD_OUT(dcmd),
    .BACKEMF_AMP_OUT(bemf), .BACKEMF_EN_OUT(bemf_en));
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    if (n_fail == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [6:0] dev = 7'h55);
    logic ok;
    u_master.wr_word(a, d, dev, ok);
    chk("write ack", {31'h0, dev == 7'h55}, {31'h0, ok});
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic ok;
    u_master.rd_word(a, 7'h55, d, ok);
    chk("read word", exp, d);
  endtask
  task automatic neg(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one brake episode: 16 sampled cycles of demand, then release and expect idle
  task automatic brk(input logic [4:0] c, input logic [15:0] e_ls, input logic [15:0] e_cc, input logic e_foc);
    logic [15:0] p_ls, p_cc;
    @(posedge clk);
    cond <= c;
    for (int k = 0; k < 16; k++) begin
      @(negedge clk);
      p_ls[k] = ls;
      p_cc[k] = cc;
    end
    chk("fet pattern", {16'h0, e_ls}, {16'h0, p_ls});
    chk("current pattern", {16'h0, e_cc}, {16'h0, p_cc});
    chk("foc decel", {31'h0, e_foc}, {31'h0, foc});
    @(posedge clk);
    cond <= '0;
    neg(2);
    chk("brake idle", 32'h0, {31'h0, act});
  endtask
  initial begin
    forever #50 clk = ~clk;
  end
  initial begin
    #9000000;
    chk("timeout", 32'h0, 32'h1);
    results();
  end
  initial begin
    neg(1);
    chk("reset outputs", 32'h8, {28'h0, st, act, ls, mon});
    @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 5; i++) rd(ADDRS[i], 32'h0);
    wr(16'h04D1, 32'hA5A5_5A5A);
    rd(16'h04D1, 32'hA5A5_5A58);
    wr(16'h0472, 32'h90C7_1483);
    rd(16'h0472, 32'h80C7_1483);
    wr(16'h0471, 32'h0801_4012);
    wr(16'h0471, 32'hFFFF_FFFF, 7'h2A);
    rd(16'h0471, 32'h0801_4010);
    neg(2);
    chk("default cmd", 32'h1400, {16'h0, dcmd});
    chk("bemf amp", 32'h0001_0200, {15'h0, bemf_en, bemf});
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      speed <= ROWS[i][35:20];
      cmd <= ROWS[i][19:4];
      neg(2);
      chk("thresholds", {28'h0, ROWS[i][3:0]}, {28'h0, ov, st, ob, mon});
    end
    @(posedge clk);
    speed <= '0;
    neg(2);
    brk(5'b00010, 16'h1E1E, 16'h0, 1'b0);
    brk(5'b10000, 16'h1E1E, 16'h0, 1'b0);
    brk(5'b00001, 16'h1E1E, 16'h0, 1'b0);
    brk(5'b00100, 16'h0, 16'h0, 1'b0);
    brk(5'b01000, 16'h0, 16'h0, 1'b1);
    wr(16'h0471, 32'h0001_400D);
    brk(5'b00010, 16'h0, 16'h0, 1'b0);
    brk(5'b01000, 16'h0, 16'hFFFE, 1'b0);
    brk(5'b00100, 16'h0, 16'hFFFE, 1'b0);
    chk("bemf off", 32'h0, {15'h0, bemf_en, bemf});
    @(posedge clk);
    speed <= 16'h1388;
    neg(2);
    @(posedge clk);
    cond <= 5'b10000;
    neg(2);
    chk("coasting", 32'h1, {31'h0, coast});
    for (int t = 0; t < 2; t++) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      neg(1);
      chk("coast exit", {30'h0, t == 0, t == 1}, {30'h0, coast, cc});
    end
    @(posedge clk);
    cond <= '0;
    speed <= '0;
    // 3 trains of 4 pulses, 8 cycles on and 16 off, then the fets hold on
    wr(16'h0471, 32'h0001_8930);
    @(posedge clk);
    cond <= 5'b00010;
    n_up = 32'h0;
    n_hi = 32'h0;
    ls_p = 1'b0;
    for (int k = 0; k < 300; k++) begin
      @(negedge clk);
      n_hi = n_hi + {31'h0, ls};
      n_up = n_up + {31'h0, ls & ~ls_p};
      ls_p = ls;
    end
    chk("pulse rises", 32'h0000_000D, n_up);
    chk("fet on cycles", 32'h0000_006B, n_hi);
    @(posedge clk);
    cond <= '0;
    rst <= 1'b1;
    neg(2);
    chk("reset again", 32'h8, {28'h0, st, act, ls, mon});
    @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd(16'h0471, 32'h0);
    results();
  end
endmodule
